// ---- verilog/cbs_pkg.sv ----
`default_nettype none
package cbs_pkg;
  localparam int ADDR_W = 23;
  localparam int SEG_W = 7;
  localparam int OFF_W = 16;
  localparam int SHORT_SEG_LSB = 8;
  localparam int SHORT_OFF_W = 8;
  localparam int CYC_MIN = 3;
  localparam int CYC_MAX = 10;
  localparam int REF_W = 9;
  localparam logic [REF_W-1:0] REF_STEP = 9'h002;
  localparam logic [REF_W-1:0] REF_RESET = 9'h000;
  localparam logic [SEG_W-1:0] SEG_RESET = 7'h00;
  localparam logic [15:0] FCW_RESET = 16'hc000;
  localparam int FCW_SEG_BIT = 15;
  localparam int FCW_SYS_BIT = 14;
  localparam int FCW_VIE_BIT = 12;
  localparam int FCW_NONVECTORED_ENABLE_BIT_BIT = 11;
  localparam logic [1:0] REG_FCW = 2'h0;
  localparam logic [1:0] REG_NEW_STATUS_AREA_POINTER_SEG = 2'h1;
  localparam logic [1:0] REG_NEW_STATUS_AREA_POINTER_OFF = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam logic [3:0] ST_INTERNAL = 4'h0;
  localparam logic [3:0] ST_REFRESH = 4'h1;
  localparam logic [3:0] ST_IO_NORMAL = 4'h2;
  localparam logic [3:0] ST_IO_SPECIAL = 4'h3;
  localparam logic [3:0] ST_MEMORY = 4'h8;
  localparam logic [1:0] PUSH_LAST = 2'h3;
  localparam logic [1:0] FETCH_FCW = 2'h0;
  localparam logic [1:0] FETCH_PC_SEG = 2'h1;
  localparam logic [1:0] FETCH_PC_OFF = 2'h2;

  typedef enum logic [2:0] {
    CYC_INTERNAL, CYC_REFRESH, CYC_IO_NORMAL, CYC_IO_SPECIAL, CYC_MEMORY
  } cbs_kind_type;

  typedef enum logic [3:0] {
    EXC_NONE, EXC_SYSCALL, EXC_SEGTRAP, EXC_UNIMPL, EXC_PRIV, EXC_NMI, EXC_VI, EXC_NVI
  } cbs_exc_type;

  typedef struct packed {
    cbs_kind_type kind;
    logic write;
    logic byte_xfer;
    logic [SEG_W-1:0] seg;
    logic [OFF_W-1:0] addr;
    logic [15:0] wdata;
  } cbs_req_type;

  typedef struct packed {
    logic address_strobe_n;
    logic [3:0] cycle_status_code;
    logic memory_request_n;
    logic data_strobe_n;
    logic read_not_write;
    logic byte_not_word;
    logic normal_not_system;
    logic [SEG_W-1:0] segment_number_out;
    logic [OFF_W-1:0] addr_data_bus;
    logic addr_data_oe;
    logic ctl_oe;
  } cbs_pins_type;
endpackage : cbs_pkg
`default_nettype wire

// ---- verilog/cbs_seg_addr.sv ----
`timescale 1ns/1ns
`default_nettype none
module cbs_seg_addr (
  input wire logic [cbs_pkg::ADDR_W-1:0] base_i,
  input wire logic [cbs_pkg::OFF_W-1:0] disp_i,
  input wire logic [15:0] short_i,
  input wire logic short_sel_i,
  output logic [cbs_pkg::ADDR_W-1:0] addr_o
);
  import cbs_pkg::*;

  wire [SEG_W-1:0] seg = short_sel_i ? short_i[SHORT_SEG_LSB+SEG_W-1:SHORT_SEG_LSB] :
                                       base_i[ADDR_W-1:OFF_W];
  wire [OFF_W-1:0] off = short_sel_i ? {8'h00, short_i[SHORT_OFF_W-1:0]} : base_i[OFF_W-1:0];
  wire [OFF_W-1:0] sum = off + disp_i;

  assign addr_o = {seg, sum};
endmodule : cbs_seg_addr
`default_nettype wire

// ---- verilog/cbs_bus_sequencer.sv ----
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_sequencer (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire cbs_pkg::cbs_req_type req_i,
  output logic req_ready_o,
  output logic cyc_done_o,
  output logic [15:0] rd_data_o,
  input wire logic wait_n_i,
  input wire logic bus_request_n_i,
  output logic bus_ack_n_o,
  input wire logic [15:0] data_bus_i,
  output cbs_pkg::cbs_pins_type pins_o,
  input wire logic nmi_n_i,
  input wire logic vi_n_i,
  input wire logic nvi_n_i,
  input wire logic segt_n_i,
  input wire logic [7:0] vector_i,
  input wire logic trap_syscall_i,
  input wire logic trap_unimpl_i,
  input wire logic trap_priv_i,
  input wire logic [cbs_pkg::ADDR_W-1:0] pc_i,
  output logic exc_ack_o,
  output cbs_pkg::cbs_exc_type exc_cause_o,
  output logic svc_push_o,
  output logic svc_fetch_o,
  output logic [15:0] svc_word_o,
  output logic [cbs_pkg::ADDR_W-1:0] svc_addr_o,
  input wire logic svc_done_i,
  input wire logic [15:0] svc_rdata_i,
  output logic [cbs_pkg::ADDR_W-1:0] new_pc_o,
  output logic new_pc_load_o,
  output logic [15:0] fcw_o,
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [cbs_pkg::ADDR_W-1:0] ea_base_i,
  input wire logic [15:0] ea_word_i,
  input wire logic ea_short_i,
  input wire logic [cbs_pkg::OFF_W-1:0] ea_disp_i,
  output logic [cbs_pkg::ADDR_W-1:0] ea_addr_o
);
  import cbs_pkg::*;

  typedef enum logic [2:0] {B_IDLE, B_T1, B_T2, B_TW, B_T3, B_HOLD} cbs_bstate_type;
  typedef enum logic [1:0] {X_IDLE, X_PUSH, X_FETCH} cbs_xstate_type;

  cbs_bstate_type state;
  cbs_bstate_type next_state;
  cbs_xstate_type xst;
  cbs_kind_type kind;
  cbs_req_type cur;
  cbs_exc_type pick;
  cbs_exc_type cause_q;
  logic [3:0] status_q;
  logic [15:0] ad_q;
  logic [SEG_W-1:0] seg_q;
  logic ns_q;
  logic rw_q;
  logic bw_q;
  logic [REF_W-1:0] ref_addr;
  logic [15:0] flag_control_word;
  logic [SEG_W-1:0] new_status_area_pointer_seg;
  logic [OFF_W-1:0] new_status_area_pointer_off;
  logic nonseg_hold;
  logic [SEG_W-1:0] code_seg;
  logic nmi_n_q;
  logic nmi_pend;
  logic sys_p;
  logic unimp_p;
  logic priv_p;
  logic [ADDR_W-1:0] saved_pc;
  logic [15:0] saved_fcw;
  logic [15:0] id_q;
  logic [1:0] step;
  logic [3:0] cyc_len;
  logic waited;
  logic [ADDR_W-1:0] fetch_addr;
  logic [ADDR_W-1:0] ea_addr;

  // grant and requests only at a boundary
  wire at_edge = (state == B_IDLE) || (state == B_T3);
  wire grant = at_edge && !bus_request_n_i;
  wire take = ce_i && at_edge && bus_request_n_i && req_valid_i;
  wire is_io = (kind == CYC_IO_NORMAL) || (kind == CYC_IO_SPECIAL);
  wire is_mem = kind == CYC_MEMORY;
  wire is_ref = kind == CYC_REFRESH;
  wire xfer = is_io || is_mem;
  wire in_cycle = state inside {B_T1, B_T2, B_TW, B_T3};
  wire data_phase = (state == B_T2) || (state == B_TW);
  wire held = state == B_HOLD;
  wire [3:0] req_code = (req_i.kind == CYC_REFRESH) ? ST_REFRESH :
                        (req_i.kind == CYC_IO_NORMAL) ? ST_IO_NORMAL :
                        (req_i.kind == CYC_IO_SPECIAL) ? ST_IO_SPECIAL :
                        (req_i.kind == CYC_MEMORY) ? ST_MEMORY : ST_INTERNAL;
  // while nonseg_hold is set, the code segment replaces the request segment
  wire [SEG_W-1:0] mem_seg = nonseg_hold ? code_seg : req_i.seg;
  // byte writes go out on both halves
  wire [15:0] wr_word = cur.byte_xfer ? {2{cur.wdata[7:0]}} : cur.wdata;
  // even byte address reads the upper half
  wire [15:0] rd_word = !cur.byte_xfer ? data_bus_i :
                        cur.addr[0] ? {8'h00, data_bus_i[7:0]} : {8'h00, data_bus_i[15:8]};
  wire drive_ad = (state == B_T1) || (in_cycle && xfer && cur.write);

  always_comb begin
    next_state = state;
    case (state)
      B_IDLE, B_T3: begin
        if (grant) begin
          next_state = B_HOLD;
        end else if (req_valid_i) begin
          next_state = B_T1;
        end else begin
          next_state = B_IDLE;
        end
      end
      B_T1: begin
        next_state = B_T2;
      end
      // I/O always takes the automatic wait
      B_T2: begin
        if (is_io || (is_mem && !wait_n_i)) begin
          next_state = B_TW;
        end else begin
          next_state = B_T3;
        end
      end
      // wait low stretches by one more state
      B_TW: begin
        next_state = wait_n_i ? B_T3 : B_TW;
      end
      B_HOLD: begin
        next_state = bus_request_n_i ? B_IDLE : B_HOLD;
      end
      default: begin
        next_state = B_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state <= B_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // cycle code latched at cycle start
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cur <= '0;
      kind <= CYC_INTERNAL;
      status_q <= ST_INTERNAL;
    end else if (take) begin
      cur <= req_i;
      kind <= req_i.kind;
      status_q <= req_code;
    end
  end

  // address in T1, write data from T2
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ad_q <= 16'h0000;
    end else if (take) begin
      ad_q <= (req_i.kind == CYC_REFRESH) ? {7'h00, ref_addr} : req_i.addr;
    end else if (ce_i && state == B_T1 && xfer && cur.write) begin
      ad_q <= wr_word;
    end
  end

  // step of two keeps bit 0 low
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ref_addr <= REF_RESET;
    end else if (take && req_i.kind == CYC_REFRESH) begin
      ref_addr <= ref_addr + REF_STEP;
    end
  end

  // transfers update the held lines; internal cycles only set read high
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rw_q <= 1'b1;
      bw_q <= 1'b0;
      ns_q <= !FCW_RESET[FCW_SYS_BIT];
    end else if (take && req_i.kind == CYC_INTERNAL) begin
      rw_q <= 1'b1;
    end else if (take && req_i.kind != CYC_REFRESH) begin
      rw_q <= !req_i.write;
      bw_q <= req_i.byte_xfer;
      ns_q <= !flag_control_word[FCW_SYS_BIT];
    end
  end

  // segment number only changes for memory cycles
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      seg_q <= SEG_RESET;
    end else if (take && req_i.kind == CYC_MEMORY) begin
      seg_q <= mem_seg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_data_o <= 16'h0000;
    end else if (ce_i && state == B_T3 && xfer && !cur.write) begin
      rd_data_o <= rd_word;
    end
  end

  // request low only for memory and refresh
  assign pins_o = '{
    address_strobe_n: state != B_T1,
    cycle_status_code: status_q,
    memory_request_n: !((is_mem || is_ref) && in_cycle),
    data_strobe_n: !(xfer && data_phase),
    read_not_write: rw_q,
    byte_not_word: bw_q,
    normal_not_system: ns_q,
    segment_number_out: seg_q,
    addr_data_bus: ad_q,
    addr_data_oe: drive_ad,
    ctl_oe: !held
  };
  assign bus_ack_n_o = !held;
  assign req_ready_o = at_edge && bus_request_n_i;
  assign cyc_done_o = ce_i && state == B_T3;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cyc_len <= 4'h0;
      waited <= 1'b0;
    end else if (take) begin
      cyc_len <= 4'h1;
      waited <= 1'b0;
    end else if (ce_i && in_cycle) begin
      cyc_len <= (cyc_len == 4'hf) ? cyc_len : cyc_len + 4'h1;
      waited <= waited || (state == B_TW && !wait_n_i) || (is_mem && state == B_T2 && !wait_n_i);
    end
  end

  wire nmi_fall = nmi_n_q && !nmi_n_i;
  assign pick = sys_p ? EXC_SYSCALL :
                !segt_n_i ? EXC_SEGTRAP :
                unimp_p ? EXC_UNIMPL :
                priv_p ? EXC_PRIV :
                nmi_pend ? EXC_NMI :
                (!vi_n_i && flag_control_word[FCW_VIE_BIT]) ? EXC_VI :
                (!nvi_n_i && flag_control_word[FCW_NONVECTORED_ENABLE_BIT_BIT]) ? EXC_NVI : EXC_NONE;
  wire accept = ce_i && xst == X_IDLE && at_edge && pick != EXC_NONE;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      nmi_n_q <= 1'b1;
      nmi_pend <= 1'b0;
      sys_p <= 1'b0;
      unimp_p <= 1'b0;
      priv_p <= 1'b0;
    end else if (ce_i) begin
      nmi_n_q <= nmi_n_i;
      nmi_pend <= nmi_fall || (nmi_pend && !(accept && pick == EXC_NMI));
      sys_p <= trap_syscall_i || (sys_p && !(accept && pick == EXC_SYSCALL));
      unimp_p <= trap_unimpl_i || (unimp_p && !(accept && pick == EXC_UNIMPL));
      priv_p <= trap_priv_i || (priv_p && !(accept && pick == EXC_PRIV));
    end
  end

  wire step_done = ce_i && svc_done_i;
  wire fetch_fcw = step_done && xst == X_FETCH && step == FETCH_FCW;

  // snapshot status and identifier on entry
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cause_q <= EXC_NONE;
      saved_pc <= '0;
      saved_fcw <= 16'h0000;
      id_q <= 16'h0000;
    end else if (accept) begin
      cause_q <= pick;
      saved_pc <= pc_i;
      saved_fcw <= flag_control_word;
      id_q <= {pick, 4'h0, (pick == EXC_VI) ? vector_i : 8'h00};
    end
  end

  // push four words, then fetch three
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      xst <= X_IDLE;
      step <= 2'h0;
    end else if (accept) begin
      xst <= X_PUSH;
      step <= 2'h0;
    end else if (step_done && xst == X_PUSH) begin
      xst <= (step == PUSH_LAST) ? X_FETCH : X_PUSH;
      step <= (step == PUSH_LAST) ? 2'h0 : step + 2'h1;
    end else if (step_done && xst == X_FETCH) begin
      xst <= (step == FETCH_PC_OFF) ? X_IDLE : X_FETCH;
      step <= (step == FETCH_PC_OFF) ? 2'h0 : step + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      new_pc_o <= '0;
      new_pc_load_o <= 1'b0;
      exc_ack_o <= 1'b0;
    end else if (ce_i) begin
      exc_ack_o <= accept;
      new_pc_load_o <= svc_done_i && xst == X_FETCH && step == FETCH_PC_OFF;
      if (svc_done_i && xst == X_FETCH && step == FETCH_PC_SEG) begin
        new_pc_o[ADDR_W-1:OFF_W] <= svc_rdata_i[SEG_W-1:0];
      end
      if (svc_done_i && xst == X_FETCH && step == FETCH_PC_OFF) begin
        new_pc_o[OFF_W-1:0] <= svc_rdata_i;
      end
    end
  end

  assign svc_push_o = xst == X_PUSH;
  assign svc_fetch_o = xst == X_FETCH;
  assign svc_word_o = (step == 2'h0) ? {9'h000, saved_pc[ADDR_W-1:OFF_W]} :
                      (step == 2'h1) ? saved_pc[OFF_W-1:0] :
                      (step == 2'h2) ? saved_fcw : id_q;
  assign exc_cause_o = cause_q;

  // slot of eight bytes per cause
  cbs_seg_addr u_fetch (
    .base_i({new_status_area_pointer_seg, new_status_area_pointer_off}),
    .disp_i({9'h000, cause_q, step, 1'b0}),
    .short_i(16'h0000),
    .short_sel_i(1'b0),
    .addr_o(fetch_addr)
  );
  assign svc_addr_o = fetch_addr;

  cbs_seg_addr u_ea (
    .base_i(ea_base_i),
    .disp_i(ea_disp_i),
    .short_i(ea_word_i),
    .short_sel_i(ea_short_i),
    .addr_o(ea_addr)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ea_addr_o <= '0;
    end else if (ce_i) begin
      ea_addr_o <= ea_addr;
    end
  end

  wire wr_fcw = ce_i && reg_wr_i && reg_addr_i == REG_FCW;
  wire wr_nseg = ce_i && reg_wr_i && reg_addr_i == REG_NEW_STATUS_AREA_POINTER_SEG;
  wire wr_noff = ce_i && reg_wr_i && reg_addr_i == REG_NEW_STATUS_AREA_POINTER_OFF;
  wire seg_to_off = wr_fcw && flag_control_word[FCW_SEG_BIT] && !reg_wdata_i[FCW_SEG_BIT];

  // status reload wins over a software write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flag_control_word <= FCW_RESET;
    end else if (fetch_fcw) begin
      flag_control_word <= svc_rdata_i;
    end else if (wr_fcw) begin
      flag_control_word <= reg_wdata_i;
    end
  end
  assign fcw_o = flag_control_word;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      new_status_area_pointer_seg <= SEG_RESET;
      new_status_area_pointer_off <= '0;
    end else begin
      if (wr_nseg) begin
        new_status_area_pointer_seg <= reg_wdata_i[SEG_W-1:0];
      end
      if (wr_noff) begin
        new_status_area_pointer_off <= reg_wdata_i;
      end
    end
  end

  // hold until interruption or segmented again
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      nonseg_hold <= 1'b0;
      code_seg <= SEG_RESET;
    end else if (seg_to_off) begin
      nonseg_hold <= 1'b1;
      code_seg <= pc_i[ADDR_W-1:OFF_W];
    end else if (accept || (wr_fcw && reg_wdata_i[FCW_SEG_BIT])) begin
      nonseg_hold <= 1'b0;
    end
  end

  wire [15:0] rsel = (reg_addr_i == REG_FCW) ? flag_control_word :
                     (reg_addr_i == REG_NEW_STATUS_AREA_POINTER_SEG) ? {9'h000, new_status_area_pointer_seg} :
                     (reg_addr_i == REG_NEW_STATUS_AREA_POINTER_OFF) ? new_status_area_pointer_off :
                     {12'h000, held, nonseg_hold, nmi_pend, xst != X_IDLE};

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rsel : 16'h0000;
    end
  end

  default clocking cb_main @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i || !ce_i);

  sequence s_fixed3;
    state == B_T1 ##1 state == B_T2 ##1 state == B_T3;
  endsequence
  sequence s_io_head;
    state == B_T1 ##1 state == B_T2 ##1 state == B_TW;
  endsequence

  chk_cycle_len: assert property (state == B_T3 && !waited |->
    cyc_len >= CYC_MIN && cyc_len <= CYC_MAX) else $error("cycle length out of range");
  chk_grant_edge: assert property ($fell(bus_ack_n_o) |->
    $past(at_edge)) else $error("bus granted inside a cycle");
  chk_start_strobe: assert property (take |=>
    !pins_o.address_strobe_n && pins_o.cycle_status_code == $past(req_code)
    ##1 pins_o.address_strobe_n) else $error("bad start strobe or code");
  chk_internal_len: assert property (take && req_i.kind == CYC_INTERNAL |=>
    s_fixed3) else $error("internal cycle not three states");
  chk_internal_quiet: assert property (kind == CYC_INTERNAL && in_cycle |->
    pins_o.memory_request_n && pins_o.data_strobe_n && pins_o.read_not_write &&
    $stable(seg_q) && $stable(ns_q) && (state == B_T1 || !pins_o.addr_data_oe))
    else $error("internal cycle lines wrong");
  chk_refresh_len: assert property (take && req_i.kind == CYC_REFRESH |=>
    s_fixed3) else $error("refresh not three states");
  chk_refresh_pins: assert property (is_ref && in_cycle |->
    !pins_o.memory_request_n && pins_o.data_strobe_n && $stable(rw_q) && $stable(bw_q) &&
    (state == B_T1 ? !ad_q[0] : !pins_o.addr_data_oe)) else $error("refresh lines wrong");
  chk_io_auto_wait: assert property (take && req_i.kind inside {CYC_IO_NORMAL, CYC_IO_SPECIAL} |=>
    s_io_head) else $error("io cycle lacks automatic wait");
  chk_io_wait_ext: assert property (state == B_TW |=>
    state == ($past(wait_n_i) ? B_T3 : B_TW)) else $error("wait sampling wrong");
  chk_io_space: assert property (is_io && state == B_T1 |->
    pins_o.memory_request_n && pins_o.cycle_status_code ==
    ((kind == CYC_IO_NORMAL) ? ST_IO_NORMAL : ST_IO_SPECIAL)) else $error("io space code wrong");
  chk_exc_prio: assert property (accept && (sys_p || unimp_p || priv_p || !segt_n_i) |->
    pick inside {EXC_SYSCALL, EXC_SEGTRAP, EXC_UNIMPL, EXC_PRIV}) else $error("trap lost priority");
  chk_vi_enable: assert property (accept && pick == EXC_VI |->
    flag_control_word[FCW_VIE_BIT] && !nmi_pend) else $error("vectored taken while disabled");
  chk_push_first: assert property (accept |=> svc_push_o && saved_pc == $past(pc_i) &&
    svc_word_o == {9'h000, saved_pc[ADDR_W-1:OFF_W]}) else $error("status push wrong");
  chk_fetch_area: assert property ($rose(svc_fetch_o) |-> $past(svc_push_o) &&
    svc_addr_o[ADDR_W-1:OFF_W] == new_status_area_pointer_seg) else $error("fetch address wrong");
  chk_nonseg_seg: assert property (nonseg_hold && take && req_i.kind == CYC_MEMORY |=>
    pins_o.segment_number_out == code_seg) else $error("code segment not shown");
  chk_nmi_latch: assert property (nmi_fall |=> nmi_pend) else $error("nmi edge lost");
endmodule : cbs_bus_sequencer
`default_nettype wire

// ---- tb/cbs_periph_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module cbs_periph_model #(
  parameter logic [15:0] RD_WORD = 16'hbeef,
  parameter logic [15:0] SVC_WORD = 16'hd034
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire cbs_pkg::cbs_pins_type pins_i,
  input wire logic [3:0] stretch_i,
  input wire logic svc_req_i,
  output logic wait_n_o,
  output logic [15:0] bus_o,
  output var logic svc_done_o,
  output logic [15:0] svc_rdata_o
);
  import cbs_pkg::*;
  logic [3:0] ds_cnt;
  logic [15:0] last_bus;
  assign wait_n_o = !(!pins_i.data_strobe_n && ds_cnt >= 4'h1 && ds_cnt <= stretch_i);
  // read data kept one state past strobe; released bus toggles so no stale value
  assign bus_o = pins_i.addr_data_oe ? pins_i.addr_data_bus :
    ((!pins_i.data_strobe_n || ds_cnt != 4'h0) && pins_i.read_not_write) ? RD_WORD : ~last_bus;
  assign svc_rdata_o = SVC_WORD;
  always_ff @(posedge sys_clk_i) begin
    last_bus <= resetn_i ? bus_o : 16'h0000;
    ds_cnt <= (!resetn_i || pins_i.data_strobe_n) ? 4'h0 : ds_cnt + 4'h1;
    svc_done_o <= resetn_i && svc_req_i && !svc_done_o;
  end
endmodule : cbs_periph_model
`default_nettype wire

// ---- tb/cbs_bus_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module cbs_bus_sequencer_tb;
  import cbs_pkg::*;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0;
  cbs_req_type req_i = '0;
  logic bus_request_n_i = 1'b1;
  logic nmi_n_i = 1'b1;
  logic vi_n_i = 1'b1;
  logic nvi_n_i = 1'b1;
  logic trap_syscall_i = 1'b0;
  logic trap_unimpl_i = 1'b0;
  logic trap_priv_i = 1'b0;
  logic tb_wait_n = 1'b1;
  logic [3:0] stretch = 4'h0;
  logic [22:0] pc_i = 23'h2a0100;
  logic [1:0] reg_addr_i = 2'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [22:0] ea_base_i = 23'h05ffff;
  logic [15:0] ea_disp_i = 16'h0001;
  logic [15:0] ea_word_i = 16'h0000;
  logic ea_short_i = 1'b0;
  logic req_ready_o, cyc_done_o, bus_ack_n_o, exc_ack_o, svc_push_o, svc_fetch_o;
  logic new_pc_load_o, p_wait, svc_done_w;
  logic [15:0] rd_data_o, bus_w, fcw_o, reg_rdata_o, svc_rdata_w, svc_word_w;
  logic [22:0] new_pc_o, ea_addr_o, svc_addr_w;
  cbs_pins_type pins_o, t1;
  cbs_exc_type exc_cause_o;
  int error_cnt = 0;
  int tests_run = 0;
  int n, cyc_cnt = 0;
  logic ack_all, ds_all, seen;

  always #5 sys_clk_i = ~sys_clk_i;

  cbs_bus_sequencer i_dut (.sys_clk_i, .resetn_i, .ce_i(1'b1), .req_valid_i, .req_i,
    .req_ready_o, .cyc_done_o, .rd_data_o, .wait_n_i(p_wait & tb_wait_n), .bus_request_n_i,
    .bus_ack_n_o, .data_bus_i(bus_w), .pins_o, .nmi_n_i, .vi_n_i, .nvi_n_i, .segt_n_i(1'b1),
    .vector_i(8'h5a), .trap_syscall_i, .trap_unimpl_i, .trap_priv_i, .pc_i, .exc_ack_o,
    .exc_cause_o, .svc_push_o, .svc_fetch_o, .svc_word_o(svc_word_w), .svc_addr_o(svc_addr_w),
    .svc_done_i(svc_done_w), .svc_rdata_i(svc_rdata_w), .new_pc_o, .new_pc_load_o, .fcw_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ea_base_i,
    .ea_word_i, .ea_short_i, .ea_disp_i, .ea_addr_o);

  cbs_periph_model i_periph (.sys_clk_i, .resetn_i, .pins_i(pins_o), .stretch_i(stretch),
    .svc_req_i(svc_push_o | svc_fetch_o), .wait_n_o(p_wait), .bus_o(bus_w),
    .svc_done_o(svc_done_w), .svc_rdata_o(svc_rdata_w));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input cbs_kind_type k, input logic [15:0] a, input logic grab);
    int g;
    g = 0;
    @(posedge sys_clk_i);
    req_i <= '{k, 1'b0, a[0], 7'h11, a, 16'h0000};
    req_valid_i <= 1'b1;
    do @(negedge sys_clk_i); while (!req_ready_o && ++g < 50);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    if (grab) bus_request_n_i <= 1'b0;
    n = 0;
    ack_all = 1'b1;
    ds_all = 1'b1;
    do begin
      @(negedge sys_clk_i);
      n++;
      if (n == 1) t1 = pins_o;
      ack_all &= bus_ack_n_o;
      ds_all &= pins_o.data_strobe_n;
    end while (!cyc_done_o && n < 20);
  endtask : cyc

  task automatic reg_op(input logic [1:0] a, input logic wr, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask : reg_op

  task automatic exc_run(input cbs_exc_type c);
    int g, pu, fe;
    logic [22:0] fa;
    logic [15:0] idw;
    g = 0;
    pu = 0;
    fe = 0;
    fa = '0;
    idw = '0;
    do @(negedge sys_clk_i); while (!exc_ack_o && ++g < 50);
    chk(exc_cause_o, c);
    @(posedge sys_clk_i);
    if (c == EXC_VI) vi_n_i <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      if (svc_fetch_o && fe == 0) fa = svc_addr_w;
      pu += (svc_done_w && svc_push_o) ? 1 : 0;
      if (pu == 4 && svc_push_o && svc_done_w) idw = svc_word_w;
      fe += (svc_done_w && svc_fetch_o) ? 1 : 0;
    end while (!new_pc_load_o && ++g < 200);
    chk(pu, 4);
    chk(idw, {c, 4'h0, (c == EXC_VI) ? 8'h5a : 8'h00});
    chk(fe, 3);
    chk(fa, {7'h03, 16'hfff8 + {9'h000, c, 3'h0}});
    chk(new_pc_o, 23'h34d034);
  endtask : exc_run

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      results();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    tb_wait_n <= 1'b0;
    cyc(CYC_INTERNAL, 16'h0000, 1'b0);
    chk(n, 3);
    chk({t1.address_strobe_n, t1.cycle_status_code}, {1'b0, ST_INTERNAL});
    chk({ds_all, t1.memory_request_n, t1.read_not_write}, 3'h7);
    cyc(CYC_REFRESH, 16'h0000, 1'b0);
    chk(n, 3);
    chk({t1.memory_request_n, ds_all, t1.cycle_status_code}, {2'h1, ST_REFRESH});
    chk(t1.addr_data_bus[0], 1'b0);
    cyc(CYC_REFRESH, 16'h0000, 1'b0);
    chk(t1.addr_data_bus[8:0], 9'h002);
    tb_wait_n <= 1'b1;
    cyc(CYC_IO_NORMAL, 16'h0040, 1'b0);
    chk(n, 4);
    chk({t1.cycle_status_code, t1.addr_data_bus}, {ST_IO_NORMAL, 16'h0040});
    @(negedge sys_clk_i);
    chk(rd_data_o, 16'hbeef);
    stretch <= 4'h2;
    cyc(CYC_IO_SPECIAL, 16'h0041, 1'b0);
    chk(n, 6);
    chk(t1.cycle_status_code, ST_IO_SPECIAL);
    @(negedge sys_clk_i);
    chk(rd_data_o[7:0], 8'hef);
    stretch <= 4'h0;
    $display("test cycles done");
    cyc(CYC_INTERNAL, 16'h0000, 1'b1);
    chk({n[30:0], ack_all}, {31'd3, 1'b1});
    @(negedge sys_clk_i);
    chk({bus_ack_n_o, pins_o.ctl_oe, pins_o.addr_data_oe}, 3'h0);
    @(posedge sys_clk_i);
    bus_request_n_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk(bus_ack_n_o, 1'b1);
    $display("test bus done");
    reg_op(REG_FCW, 1'b1, 16'h4000);
    cyc(CYC_MEMORY, 16'h0100, 1'b0);
    chk(t1.segment_number_out, 7'h2a);
    reg_op(REG_FCW, 1'b1, 16'hd000);
    cyc(CYC_MEMORY, 16'h0100, 1'b0);
    chk({t1.segment_number_out, t1.addr_data_bus}, 23'h110100);
    chk(ea_addr_o, 23'h050000);
    chk(fcw_o, 16'hd000);
    reg_op(REG_NEW_STATUS_AREA_POINTER_SEG, 1'b1, 16'h0003);
    reg_op(REG_NEW_STATUS_AREA_POINTER_OFF, 1'b1, 16'hfff8);
    ea_word_i <= 16'h8312;
    ea_short_i <= 1'b1;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(ea_addr_o, 23'h030013);
    $display("test mode done");
    @(posedge sys_clk_i);
    trap_syscall_i <= 1'b1;
    trap_unimpl_i <= 1'b1;
    trap_priv_i <= 1'b1;
    nmi_n_i <= 1'b0;
    @(posedge sys_clk_i);
    trap_syscall_i <= 1'b0;
    trap_unimpl_i <= 1'b0;
    trap_priv_i <= 1'b0;
    nmi_n_i <= 1'b1;
    // interrupts a cycle late so the trap pulses are latched first
    vi_n_i <= 1'b0;
    nvi_n_i <= 1'b0;
    exc_run(EXC_SYSCALL);
    exc_run(EXC_UNIMPL);
    exc_run(EXC_PRIV);
    exc_run(EXC_NMI);
    exc_run(EXC_VI);
    seen = 1'b0;
    repeat (20) begin
      @(negedge sys_clk_i);
      seen |= exc_ack_o;
    end
    chk(seen, 1'b0);
    reg_op(REG_FCW, 1'b0, 16'h0000);
    @(negedge sys_clk_i);
    chk(reg_rdata_o, 16'hd034);
    $display("test exceptions done");
    results();
  end
endmodule : cbs_bus_sequencer_tb
`default_nettype wire
